// file: rtl/lfb_frame_ctrl.sv
// Purpose: lcd drive timing, frame inversion, blink, auto scroll, update handshake
// Assumes: sfr strobes come from logic on clk; main config comes from the lcd config sfr
// Notes:   read data appears one cycle after sfrRdEn
//
// Overview of operation
// - auto scroll steps the shown screen through all four banks by itself
// - scroll period comes from the blink rate field
// - with auto scroll and blink both on, scroll runs and blink is suppressed
// - frame invert set inverts alternate frames; clear means no inversion
// - screen select field picks which of the four banks is shown
// - update done flag sets once a new frame starts after memory is taken up
// - hold update set stops using data registers; processor rewrites them freely
// - hold update cleared resumes data registers at the next frame boundary
// - blink source 00 is software blink blanked, 01 software blink shown
// - blink source 10 blinks at two hertz
// - blink source 11 takes blink rate from the rate field
// - rate field gives 1, 1/2, 1/3, 1/4 hertz blink
// - fast source 2x mux drives 2048/(4*(fd+1)), fd 0 gives 16 Hz
// - fast source 3x/4x drives 2048/(2*(fd+1)), 3x fd 1 341.3, fd 0 32 Hz
// - blinking only when main blink enable is set
// - mux field 01, 10, 11 gives 2x, 3x, 4x; 00 reserved
module lfb_frame_ctrl #(
	parameter int FAST_CYCLES  = lfb_pkg::SRC_FAST_CYCLES,
	parameter int SLOW_CYCLES  = lfb_pkg::SRC_SLOW_CYCLES,
	parameter int BLINK_CYCLES = lfb_pkg::BLINK_TICK_CYCLES
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// sfr port
	input  wire logic [7:0]             sfrAddr,
	input  wire logic                   sfrWrEn,
	input  wire logic [7:0]             sfrWrData,
	input  wire logic                   sfrRdEn,
	output logic      [7:0]             sfrRdData,
	// main lcd configuration
	input  wire lfb_pkg::lfb_main_cfg_t mainCfg,
	// drive control toward segment and common drivers
	output lfb_pkg::lfb_drive_t         drive
);
	import lfb_pkg::*;

	localparam int CW = $clog2(SLOW_CYCLES + 1);
	localparam int BW = $clog2(BLINK_CYCLES + 1);

	if (FAST_CYCLES < 1 || SLOW_CYCLES < FAST_CYCLES || BLINK_CYCLES < 1) begin : g_chk
		$error("lfb_frame_ctrl: bad cycle counts");
	end

	// ------------------------------------------------------------
	// registers and update handshake
	// ------------------------------------------------------------
	logic [7:0] clkCfg, next_clkCfg;
	logic [7:0] scrCtl, next_scrCtl;
	logic       doneFlag, next_doneFlag;
	lfb_upd_t   updState, next_updState;
	logic [7:0] next_sfrRdData;
	logic       frameStart;

	logic       autoEn, invEn, holdBit, wrScroll;
	logic [1:0] blkMode, blkRate, screenSel;
	logic [3:0] fd;
	assign autoEn    = scrCtl[SC_AUTO];
	assign invEn     = scrCtl[SC_INV];
	assign holdBit   = scrCtl[SC_HOLD];
	assign screenSel = scrCtl[SC_SCR_LO +: 2];
	assign blkMode   = clkCfg[CK_MODE_LO +: 2];
	assign blkRate   = clkCfg[CK_RATE_LO +: 2];
	assign fd        = clkCfg[CK_FD_LO +: 4];
	assign wrScroll  = sfrWrEn && sfrAddr == ADDR_SCROLL_CTL;

	always_comb begin
		next_clkCfg   = clkCfg;
		next_scrCtl   = scrCtl;
		next_doneFlag = doneFlag;
		next_updState = updState;
		if (sfrWrEn && sfrAddr == ADDR_CLK_BLINK) begin
			next_clkCfg = sfrWrData;
		end
		if (wrScroll) begin
			next_scrCtl = sfrWrData;
			// software may only clear the done flag
			if (!sfrWrData[SC_DONE]) begin
				next_doneFlag = 1'b0;
			end
		end
		unique case (updState)
			LFB_UPD_RUN: begin
				if (next_scrCtl[SC_HOLD]) begin
					next_updState = LFB_UPD_HOLD;
				end
			end
			LFB_UPD_HOLD: begin
				if (!next_scrCtl[SC_HOLD]) begin
					next_updState = LFB_UPD_PEND;
				end
			end
			LFB_UPD_PEND: begin
				if (next_scrCtl[SC_HOLD]) begin
					next_updState = LFB_UPD_HOLD;
				end else if (frameStart) begin
					next_updState = LFB_UPD_RUN;
					next_doneFlag = 1'b1;
				end
			end
			default: begin
				next_updState = LFB_UPD_RUN;
			end
		endcase
		next_sfrRdData = 8'h00;
		if (sfrRdEn && sfrAddr == ADDR_CLK_BLINK) begin
			next_sfrRdData = clkCfg;
		end else if (sfrRdEn && sfrAddr == ADDR_SCROLL_CTL) begin
			next_sfrRdData = {scrCtl[7:2], doneFlag, scrCtl[SC_HOLD]};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			clkCfg    <= RST_CLK_BLINK;
			scrCtl    <= RST_SCROLL_CTL;
			doneFlag  <= 1'b0;
			updState  <= LFB_UPD_RUN;
			sfrRdData <= 8'h00;
		end else begin
			clkCfg    <= next_clkCfg;
			scrCtl    <= next_scrCtl;
			doneFlag  <= next_doneFlag;
			updState  <= next_updState;
			sfrRdData <= next_sfrRdData;
		end
	end

	// ------------------------------------------------------------
	// drive and frame timing
	// ------------------------------------------------------------
	function automatic logic [7:0] drvPeriodOf(input logic slow, input logic [1:0] mux,
		input logic [3:0] fdv);
		logic       two;
		logic [4:0] fdp;
		two = (mux == MUX_2X) || (mux == MUX_RSVD);
		fdp = {1'b0, fdv} + 5'h01;
		if (slow) begin
			if (fdv == 4'hf) return 8'h01;
			if (fdv == 4'h0) return 8'h02;
			if (two && fdv == 4'h2) return 8'h06;
			if (two && fdv >= 4'h3) return 8'h08;
			return 8'h04;
		end
		if (fdv == 4'h0) return two ? 8'h80 : 8'h40;
		if (two) return {1'b0, fdp, 2'b00};
		if (mux == MUX_3X && fdv == 4'h1) return 8'h06;
		return {2'b00, fdp, 1'b0};
	endfunction : drvPeriodOf

	logic [CW-1:0] srcCnt, next_srcCnt;
	logic [7:0]    drvCnt, next_drvCnt;
	logic [1:0]    comIdx, next_comIdx;
	logic          invPhase, next_invPhase;
	logic [BW-1:0] baseCnt, next_baseCnt;
	logic [3:0]    blinkCnt, next_blinkCnt;
	logic          blinkPhase, next_blinkPhase;
	logic [4:0]    scrollCnt, next_scrollCnt;
	logic          scrollPend, next_scrollPend;
	logic [1:0]    autoScreen, next_autoScreen;
	lfb_drive_t    next_drive;
	logic [CW-1:0] srcPeriod;
	logic [7:0]    drvPeriod;
	logic [1:0]    comLast;
	logic [3:0]    blinkHalf;
	logic [4:0]    scrollPeriod;
	logic          srcTick, drvTick, qTick;

	always_comb begin
		srcPeriod = mainCfg.sourceClockSelect ? CW'(SLOW_CYCLES) : CW'(FAST_CYCLES);
		drvPeriod = drvPeriodOf(mainCfg.sourceClockSelect, mainCfg.muxLevel, fd);
		// reserved mux code runs as 2x
		unique case (mainCfg.muxLevel)
			MUX_3X:  comLast = 2'h2;
			MUX_4X:  comLast = 2'h3;
			default: comLast = 2'h1;
		endcase
		unique case (blkMode)
			BLK_2HZ: blinkHalf = HALF_2HZ;
			default: blinkHalf = {1'b0, blkRate, 1'b0} + 4'h2;
		endcase
		scrollPeriod = {1'b0, blkRate, 2'b00} + 5'h04;
		srcTick    = srcCnt >= srcPeriod - CW'(1);
		drvTick    = srcTick && drvCnt >= drvPeriod - 8'h01;
		frameStart = drvTick && comIdx >= comLast;
		qTick      = baseCnt >= BW'(BLINK_CYCLES - 1);

		next_srcCnt = srcTick ? '0 : srcCnt + CW'(1);
		next_drvCnt = drvTick ? 8'h00 : (srcTick ? drvCnt + 8'h01 : drvCnt);
		next_comIdx = frameStart ? 2'h0 : (drvTick ? comIdx + 2'h1 : comIdx);
		next_invPhase = invPhase;
		if (frameStart) begin
			next_invPhase = invEn && !invPhase;
		end
		next_baseCnt    = qTick ? '0 : baseCnt + BW'(1);
		next_blinkCnt   = blinkCnt;
		next_blinkPhase = blinkPhase;
		if (qTick) begin
			if (blinkCnt >= blinkHalf - 4'h1) begin
				next_blinkCnt   = 4'h0;
				next_blinkPhase = !blinkPhase;
			end else begin
				next_blinkCnt = blinkCnt + 4'h1;
			end
		end
		next_scrollCnt  = scrollCnt;
		next_scrollPend = scrollPend && autoEn;
		next_autoScreen = autoEn ? autoScreen : screenSel;
		if (autoEn && qTick) begin
			if (scrollCnt >= scrollPeriod - 5'h01) begin
				next_scrollCnt  = 5'h00;
				next_scrollPend = 1'b1;
			end else begin
				next_scrollCnt = scrollCnt + 5'h01;
			end
		end else if (!autoEn) begin
			next_scrollCnt = 5'h00;
		end
		if (autoEn && frameStart && scrollPend) begin
			next_autoScreen = autoScreen + 2'h1;
			next_scrollPend = 1'b0;
		end

		next_drive.useDataRegs = next_updState == LFB_UPD_RUN;
		next_drive.frameInvert = next_invPhase;
		next_drive.screen      = autoEn ? next_autoScreen : screenSel;
		next_drive.comIndex    = next_comIdx;
		next_drive.frameStart  = frameStart;
		next_drive.driveTick   = drvTick;
		next_drive.displayBlank = 1'b0;
		if (!autoEn && mainCfg.blinkEnable) begin
			unique case (blkMode)
				BLK_SW_OFF: next_drive.displayBlank = 1'b1;
				BLK_SW_ON:  next_drive.displayBlank = 1'b0;
				default:    next_drive.displayBlank = next_blinkPhase;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			srcCnt     <= '0;
			drvCnt     <= 8'h00;
			comIdx     <= 2'h0;
			invPhase   <= 1'b0;
			baseCnt    <= '0;
			blinkCnt   <= 4'h0;
			blinkPhase <= 1'b0;
			scrollCnt  <= 5'h00;
			scrollPend <= 1'b0;
			autoScreen <= 2'h0;
			drive      <= '0;
		end else begin
			srcCnt     <= next_srcCnt;
			drvCnt     <= next_drvCnt;
			comIdx     <= next_comIdx;
			invPhase   <= next_invPhase;
			baseCnt    <= next_baseCnt;
			blinkCnt   <= next_blinkCnt;
			blinkPhase <= next_blinkPhase;
			scrollCnt  <= next_scrollCnt;
			scrollPend <= next_scrollPend;
			autoScreen <= next_autoScreen;
			drive      <= next_drive;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_scroll_step;
		autoEn && frameStart && scrollPend |=> autoScreen == $past(autoScreen) + 2'h1;
	endproperty
	a_scroll_step: assert property (p_scroll_step) else $error("scroll step missed");

	property p_scroll_rate;
		autoEn && qTick && scrollCnt == scrollPeriod - 5'h01 |=> scrollPend;
	endproperty
	a_scroll_rate: assert property (p_scroll_rate) else $error("scroll rate wrong");

	property p_scroll_no_blink;
		autoEn |=> !drive.displayBlank;
	endproperty
	a_scroll_no_blink: assert property (p_scroll_no_blink) else $error("blink not suppressed");

	property p_invert;
		frameStart |=> drive.frameInvert == ($past(invEn) && !$past(drive.frameInvert));
	endproperty
	a_invert: assert property (p_invert) else $error("frame inversion wrong");

	property p_screen_sel;
		!autoEn |=> drive.screen == $past(screenSel);
	endproperty
	a_screen_sel: assert property (p_screen_sel) else $error("screen select wrong");

	property p_done_set;
		updState == LFB_UPD_PEND && frameStart && !wrScroll |=> doneFlag && drive.useDataRegs;
	endproperty
	a_done_set: assert property (p_done_set) else $error("update done not set");

	property p_hold;
		holdBit |-> !drive.useDataRegs;
	endproperty
	a_hold: assert property (p_hold) else $error("data regs used while held");

	property p_no_early_resume;
		updState == LFB_UPD_PEND |-> !drive.useDataRegs;
	endproperty
	a_no_early_resume: assert property (p_no_early_resume) else $error("resumed early");

	property p_blink_off_sw;
		!autoEn && mainCfg.blinkEnable && blkMode == BLK_SW_OFF |=> drive.displayBlank;
	endproperty
	a_blink_off_sw: assert property (p_blink_off_sw) else $error("sw blank wrong");

	property p_blink_half;
		qTick && blinkCnt >= blinkHalf - 4'h1 |=> blinkPhase != $past(blinkPhase);
	endproperty
	a_blink_half: assert property (p_blink_half) else $error("blink half period wrong");

	property p_no_blink;
		!mainCfg.blinkEnable |=> !drive.displayBlank;
	endproperty
	a_no_blink: assert property (p_no_blink) else $error("blank without enable");

	property p_fast_2x_fd0;
		!mainCfg.sourceClockSelect && mainCfg.muxLevel == MUX_2X && fd == 4'h0
			|-> drvPeriod == 8'h80;
	endproperty
	a_fast_2x_fd0: assert property (p_fast_2x_fd0) else $error("2x fd0 period wrong");

	property p_fast_3x_fd1;
		!mainCfg.sourceClockSelect && mainCfg.muxLevel == MUX_3X && fd == 4'h1
			|-> drvPeriod == 8'h06;
	endproperty
	a_fast_3x_fd1: assert property (p_fast_3x_fd1) else $error("3x fd1 period wrong");

	property p_slow_fd15;
		mainCfg.sourceClockSelect && fd == 4'hf |-> drvPeriod == 8'h01;
	endproperty
	a_slow_fd15: assert property (p_slow_fd15) else $error("slow fd15 period wrong");

	c_frame: cover property (frameStart && invEn);
	c_done: cover property (updState == LFB_UPD_PEND ##1 doneFlag);
	c_scroll: cover property (autoEn && frameStart && scrollPend);
	c_blink: cover property (!autoEn && mainCfg.blinkEnable && $changed(drive.displayBlank));

endmodule : lfb_frame_ctrl

// file: shared/lfb_pkg.sv
// Purpose: constants and carriers for the lcd frame, blink and scroll control
// Assumes: 10 MHz system clock; lcd source rates derived by enable pulses
// Notes:   register offsets are special-function addresses on the core's sfr port
package lfb_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CLK_BLINK  = 8'h96;
	localparam logic [7:0] ADDR_SCROLL_CTL = 8'hb1;
	localparam logic [7:0] RST_CLK_BLINK   = 8'h00;
	localparam logic [7:0] RST_SCROLL_CTL  = 8'h00;

	// scroll control fields
	localparam int SC_AUTO   = 7;
	localparam int SC_INV    = 6;
	localparam int SC_SCR_LO = 2;
	localparam int SC_DONE   = 1;
	localparam int SC_HOLD   = 0;

	// clock and blink fields
	localparam int CK_MODE_LO = 6;
	localparam int CK_RATE_LO = 4;
	localparam int CK_FD_LO   = 0;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] MUX_RSVD = 2'h0;
	localparam logic [1:0] MUX_2X   = 2'h1;
	localparam logic [1:0] MUX_3X   = 2'h2;
	localparam logic [1:0] MUX_4X   = 2'h3;

	localparam logic [1:0] BLK_SW_OFF = 2'h0;
	localparam logic [1:0] BLK_SW_ON  = 2'h1;
	localparam logic [1:0] BLK_2HZ    = 2'h2;
	localparam logic [1:0] BLK_RATE   = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 10_000_000;
	localparam int SRC_FAST_HZ  = 2048;
	localparam int SRC_SLOW_HZ  = 128;
	localparam int BLINK_TICK_HZ = 4;
	localparam int SRC_FAST_CYCLES = CLK_HZ / SRC_FAST_HZ;
	localparam int SRC_SLOW_CYCLES = CLK_HZ / SRC_SLOW_HZ;
	localparam int BLINK_TICK_CYCLES = CLK_HZ / BLINK_TICK_HZ;
	// half blink period in quarter-second ticks
	localparam logic [3:0] HALF_2HZ = 4'h1;

	typedef enum logic [1:0] {
		LFB_UPD_RUN  = 2'b00,
		LFB_UPD_HOLD = 2'b01,
		LFB_UPD_PEND = 2'b10
	} lfb_upd_t;

	typedef struct packed {
		logic       blinkEnable;
		logic       sourceClockSelect;
		logic [1:0] muxLevel;
	} lfb_main_cfg_t;

	typedef struct packed {
		logic       useDataRegs;
		logic       displayBlank;
		logic       frameInvert;
		logic [1:0] screen;
		logic [1:0] comIndex;
		logic       frameStart;
		logic       driveTick;
	} lfb_drive_t;

endpackage : lfb_pkg

// file: test/lfb_panel_model.sv
// Purpose: lcd glass model counting frames and inverted frames
// Assumes: frameInvert is valid in the frameStart cycle
// Notes:   the glass only loads the block, it drives nothing back
module lfb_panel_model (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// drive from the block
	input  wire lfb_pkg::lfb_drive_t drive,
	// frame statistics
	output logic              [15:0] frameCount,
	output logic              [15:0] invertCount
);
	import lfb_pkg::*;

	always_ff @(posedge clk) begin
		if (reset) begin
			frameCount  <= 16'h0000;
			invertCount <= 16'h0000;
		end else if (drive.frameStart) begin
			frameCount  <= frameCount + 16'h0001;
			invertCount <= invertCount + {15'h0000, drive.frameInvert};
		end
	end
endmodule : lfb_panel_model

// file: test/testbench.sv
// Purpose: self-checking bench for the lcd frame, blink and scroll control
// Assumes: short source and blink counts set by parameters
// Notes:   expectations come from the bench functions below
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin failCount++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import lfb_pkg::*;

	localparam int FC = 4;
	localparam int SC = 8;
	localparam int BC = 64;
	logic          clk       = 1'b0;
	logic          reset     = 1'b1;
	logic [7:0]    sfrAddr   = 8'h00;
	logic          sfrWrEn   = 1'b0;
	logic [7:0]    sfrWrData = 8'h00;
	logic          sfrRdEn   = 1'b0;
	logic [7:0]    sfrRdData;
	lfb_main_cfg_t mainCfg   = 4'h1;
	lfb_drive_t    drive;
	logic [15:0]   frameCount;
	logic [15:0]   invertCount;
	logic [31:0]   rnd       = 32'h7c863136;
	int            failCount = 0;
	int            testsRun  = 0;
	int            cyc       = 0;

	lfb_frame_ctrl #(.FAST_CYCLES(FC), .SLOW_CYCLES(SC), .BLINK_CYCLES(BC)) i_lfb_frame_ctrl (
		.clk(clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
		.mainCfg(mainCfg), .drive(drive));
	lfb_panel_model i_lfb_panel_model (.clk(clk), .reset(reset), .drive(drive),
		.frameCount(frameCount), .invertCount(invertCount));

	always #50 clk = ~clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] nextRnd(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nextRnd

	// source ticks per drive tick
	function automatic int drvTicks(input logic [1:0] mx, input logic [3:0] fd, input logic sl);
		if (sl) return fd == 4'h0 ? 2 : fd == 4'hf ? 1 : mx > MUX_2X ? 4 : fd == 4'h1 ? 4 :
			fd == 4'h2 ? 6 : 8;
		if (mx == MUX_3X && fd == 4'h1) return 6;
		if (mx <= MUX_2X) return fd == 4'h0 ? 128 : 4 * (fd + 1);
		return fd == 4'h0 ? 64 : 2 * (fd + 1);
	endfunction : drvTicks

	task automatic endOfTest;
		$display("tests %0d failures %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : endOfTest

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrEn <= 1'b1;
		@(posedge clk);
		sfrWrEn <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge clk);
		sfrRdEn <= 1'b0;
		#1 d = sfrRdData;
	endtask : rd

	// 0 drive tick, 1 frame start, 2 screen change, 3 blank change
	task automatic waitEv(input int sel, output int n, input int cap = 4000);
		lfb_drive_t p;
		p = drive;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (n < cap && !(sel == 0 && drive.driveTick || sel == 1 && drive.frameStart ||
			sel == 2 && drive.screen !== p.screen || sel == 3 && drive.displayBlank !== p.displayBlank));
	endtask : waitEv

	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			failCount++;
			endOfTest();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0]  d;
		logic [3:0]  fd;
		logic [15:0] c;
		lfb_drive_t  p;
		int          n;
		int          e;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(ADDR_CLK_BLINK, d);
		`CHK("clkReset", RST_CLK_BLINK, d)
		rd(ADDR_SCROLL_CTL, d);
		`CHK("scrReset", RST_SCROLL_CTL, d)
		rnd = nextRnd(rnd);
		wr(ADDR_CLK_BLINK, rnd[7:0]);
		wr(8'h97, 8'hff);
		rd(8'h97, d);
		`CHK("unmapped", 8'h00, d)
		rd(ADDR_CLK_BLINK, d);
		`CHK("clkRw", rnd[7:0], d)
		for (int s = 0; s < 4; s++) begin
			rnd = nextRnd(rnd);
			wr(ADDR_SCROLL_CTL, {1'b0, rnd[6], 2'b00, s[1:0], 2'b00});
			waitEv(1, n);
			`CHK("screen", s[1:0], drive.screen)
			rd(ADDR_SCROLL_CTL, d);
			`CHK("scrRw", {1'b0, rnd[6], 2'b00, s[1:0], 2'b00}, d)
		end
		$display("registers done");
		for (int sl = 0; sl < 2; sl++)
			for (int mx = 0; mx < 4; mx++)
				for (int k = 0; k < 5; k++) begin
					rnd = nextRnd(rnd);
					fd = k == 4 ? rnd[3:0] : k == 3 ? 4'hf : k[3:0];
					@(posedge clk);
					mainCfg <= {1'b0, sl[0], mx[1:0]};
					wr(ADDR_CLK_BLINK, {4'h0, fd});
					repeat (2) waitEv(0, n);
					waitEv(0, n);
					e = drvTicks(mx[1:0], fd, sl[0]) * (sl ? SC : FC);
					`CHK("driveGap", e, n)
					waitEv(1, n);
					waitEv(1, n);
					`CHK("frameGap", e * (mx == 0 ? 2 : mx + 1), n)
					`CHK("comIdx", 2'h0, drive.comIndex)
				end
		$display("timing done");
		@(posedge clk);
		mainCfg <= 4'h3;
		wr(ADDR_CLK_BLINK, 8'h01);
		wr(ADDR_SCROLL_CTL, 8'h01);
		`CHK("holdUse", 1'b0, drive.useDataRegs)
		rd(ADDR_SCROLL_CTL, d);
		`CHK("holdRead", 8'h01, d)
		wr(ADDR_SCROLL_CTL, 8'h00);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
			if (!drive.frameStart) `CHK("pendUse", 1'b0, drive.useDataRegs)
		end while (!drive.frameStart && n < 200);
		`CHK("resume", 1'b1, drive.useDataRegs)
		rd(ADDR_SCROLL_CTL, d);
		`CHK("doneSet", 8'h02, d)
		wr(ADDR_SCROLL_CTL, 8'h02);
		rd(ADDR_SCROLL_CTL, d);
		`CHK("doneKeep", 8'h02, d)
		wr(ADDR_SCROLL_CTL, 8'h00);
		repeat (2) waitEv(1, n);
		rd(ADDR_SCROLL_CTL, d);
		`CHK("doneClr", 8'h00, d)
		$display("handshake done");
		wr(ADDR_SCROLL_CTL, 8'h40);
		repeat (2) waitEv(1, n);
		c = invertCount;
		repeat (8) waitEv(1, n);
		`CHK("invAlt", 16'h0004, invertCount - c)
		wr(ADDR_SCROLL_CTL, 8'h00);
		repeat (2) waitEv(1, n);
		c = invertCount;
		repeat (4) waitEv(1, n);
		`CHK("invOff", 16'h0000, invertCount - c)
		$display("inversion done");
		@(posedge clk);
		mainCfg <= 4'hb;
		wr(ADDR_CLK_BLINK, 8'h01);
		`CHK("swOff", 1'b1, drive.displayBlank)
		wr(ADDR_CLK_BLINK, 8'h41);
		`CHK("swOn", 1'b0, drive.displayBlank)
		wr(ADDR_CLK_BLINK, 8'h81);
		repeat (2) waitEv(3, n);
		waitEv(3, n);
		`CHK("blink2Hz", int'(HALF_2HZ) * BC, n)
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_CLK_BLINK, {2'b11, r[1:0], 4'h1});
			repeat (2) waitEv(3, n);
			waitEv(3, n);
			`CHK("blinkRate", 2 * (r + 1) * BC, n)
		end
		@(posedge clk);
		mainCfg <= 4'h3;
		wr(ADDR_CLK_BLINK, 8'h81);
		waitEv(3, n, 300);
		`CHK("blinkOff", 300, n)
		`CHK("blinkOffLvl", 1'b0, drive.displayBlank)
		for (int r = 0; r < 4; r += 3) begin
			wr(ADDR_CLK_BLINK, {2'b10, r[1:0], 4'h1});
			wr(ADDR_SCROLL_CTL, 8'h88);
			@(posedge clk);
			mainCfg <= 4'hb;
			repeat (2) waitEv(2, n);
			p = drive;
			for (int k = 0; k < 4; k++) begin
				waitEv(2, n);
				`CHK("scrollStep", p.screen + 2'h1, drive.screen)
				`CHK("scrollGap", 4 * (r + 1) * BC, n)
				`CHK("scrollNoBlink", 1'b0, drive.displayBlank)
				p = drive;
			end
		end
		$display("blink and scroll done");
		endOfTest();
	end
endmodule : testbench
